// *** verilog/add_group_pkg.sv ***
// Behaviour
// RULE1 - s bit picks global or local source
// RULE2 - d bit picks global or local destination
// RULE3 - plain add writes sum to destination
// RULE4 - status word source adds carry instead
// RULE5 - carry add: destination plus source plus carry
// RULE6 - no exception, overflow only recorded
// RULE7 - decode carry add opcode, status variant
// RULE8 - immediate selector is bit8 over bits3..0
// RULE9 - zero selector: round-to-even carry add
// RULE10 - update zero, negative, overflow, carry flags
// RULE11 - nonzero selector expands through immediate table
// RULE12 - plain add has its own opcode
`default_nettype none
package add_group_pkg;

	// ----------------------------------------
	// widths and instruction fields
	// ----------------------------------------
	localparam int DATA_W      = 32;
	localparam int INSTR_W     = 16;
	localparam int INDEX_W     = 4;
	localparam int GROUP_N     = 16;
	localparam int SEL_W       = 5;
	localparam int IMM_N       = 32;
	localparam int OPC_HI      = 15;
	localparam int OPC_LO      = 10;
	localparam int DST_SEL_BIT = 9;
	localparam int SRC_SEL_BIT = 8;
	localparam int DST_HI      = 7;
	localparam int DST_LO      = 4;
	localparam int SRC_HI      = 3;
	localparam int SRC_LO      = 0;
	localparam int IMM_HI_BIT  = 8;

	localparam logic [5:0] OPC_SUM       = 6'h0a;
	localparam logic [5:0] OPC_SUM_CARRY = 6'h14;
	localparam logic [5:0] OPC_SUM_IMM   = 6'h1a;
	localparam logic [INDEX_W-1:0] STATUS_INDEX = 4'h1;

	typedef enum logic [1:0] {OP_NONE, OP_SUM, OP_SUM_CARRY, OP_SUM_IMM} op_kind_e;

	// ----------------------------------------
	// flags and register map
	// ----------------------------------------
	localparam int FLAG_W = 4;
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam logic [FLAG_W-1:0]  FLAGS_RESET = 4'h0;
	localparam logic [INSTR_W-1:0] INSTR_RESET = 16'h0000;

	localparam int ADDR_W = 9;
	localparam logic [ADDR_W-1:0] ADR_CTRL   = 9'h000;
	localparam logic [ADDR_W-1:0] ADR_INSTR  = 9'h004;
	localparam logic [ADDR_W-1:0] ADR_FLAGS  = 9'h008;
	localparam logic [ADDR_W-1:0] ADR_RESULT = 9'h00c;
	localparam logic [2:0] REGION_GLOBAL = 3'h4;
	localparam logic [2:0] REGION_LOCAL  = 3'h5;
	localparam logic [1:0] REGION_IMM    = 2'h3;
	localparam int CTRL_START    = 0;
	localparam int CTRL_CLR_DONE = 1;
	localparam int STAT_BUSY     = 0;
	localparam int STAT_DONE     = 1;
	localparam int STAT_BAD_OP   = 2;

endpackage
`default_nettype wire

// *** verilog/instr_fields_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface instr_fields_if;
	logic [add_group_pkg::INSTR_W-1:0] instr;
	add_group_pkg::op_kind_e           op;
	logic                              dst_local;
	logic [add_group_pkg::INDEX_W-1:0] dst_index;
	logic                              src_local;
	logic [add_group_pkg::INDEX_W-1:0] src_index;
	logic                              src_is_status;
	logic [add_group_pkg::SEL_W-1:0]   imm_sel;

	modport decode (input instr, output op, output dst_local, output dst_index,
		output src_local, output src_index, output src_is_status, output imm_sel);
	modport exec (output instr, input op, input dst_local, input dst_index,
		input src_local, input src_index, input src_is_status, input imm_sel);
endinterface
`default_nettype wire

// *** verilog/op_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module op_decoder
(
	instr_fields_if.decode fields
);

	logic [5:0] opcode;

	always_comb
	begin
		opcode              = fields.instr[add_group_pkg::OPC_HI:add_group_pkg::OPC_LO];
		fields.dst_local    = fields.instr[add_group_pkg::DST_SEL_BIT]; // RULE2
		fields.dst_index    = fields.instr[add_group_pkg::DST_HI:add_group_pkg::DST_LO]; // RULE2
		fields.src_local    = fields.instr[add_group_pkg::SRC_SEL_BIT]; // RULE1
		fields.src_index    = fields.instr[add_group_pkg::SRC_HI:add_group_pkg::SRC_LO]; // RULE1
		fields.src_is_status = !fields.src_local && (fields.src_index == add_group_pkg::STATUS_INDEX);
		fields.imm_sel      = {fields.instr[add_group_pkg::IMM_HI_BIT],
			fields.instr[add_group_pkg::SRC_HI:add_group_pkg::SRC_LO]}; // RULE8
		unique case (opcode)
			add_group_pkg::OPC_SUM:       fields.op = add_group_pkg::OP_SUM; // RULE12
			add_group_pkg::OPC_SUM_CARRY: fields.op = add_group_pkg::OP_SUM_CARRY; // RULE7
			add_group_pkg::OPC_SUM_IMM:   fields.op = add_group_pkg::OP_SUM_IMM;
			default:                      fields.op = add_group_pkg::OP_NONE;
		endcase
	end

endmodule
`default_nettype wire

// *** verilog/sum_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module sum_unit
#(
	parameter int W = add_group_pkg::DATA_W
)
(
	input  wire logic [W-1:0] a_in,
	input  wire logic [W-1:0] b_in,
	input  wire logic         carry_in,
	output logic      [W-1:0] sum_out,
	output logic              carry_out,
	output logic              overflow_out,
	output logic              zero_out,
	output logic              negative_out
);

	logic [W:0] wide;

	// same operand signs but a different result sign is signed overflow
	always_comb
	begin
		wide         = {1'b0, a_in} + {1'b0, b_in} + {{W{1'b0}}, carry_in};
		sum_out      = wide[W-1:0];
		carry_out    = wide[W];
		overflow_out = (a_in[W-1] == b_in[W-1]) && (wide[W-1] != a_in[W-1]);
		zero_out     = (wide[W-1:0] == '0);
		negative_out = wide[W-1];
	end

endmodule
`default_nettype wire

// *** verilog/add_group_top.sv ***
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module add_group_top
(
	input  wire logic                              clk_in,
	input  wire logic                              reset_in,
	input  wire logic [add_group_pkg::ADDR_W-1:0]  avs_address_in,
	input  wire logic                              avs_read_in,
	input  wire logic                              avs_write_in,
	input  wire logic [add_group_pkg::DATA_W-1:0]  avs_writedata_in,
	input  wire logic [3:0]                        avs_byteenable_in,
	output logic      [add_group_pkg::DATA_W-1:0]  avs_readdata_out,
	output logic                                   avs_waitrequest_out
);

	typedef enum logic {ST_IDLE, ST_EXEC} exec_state_e;

	localparam int DW = add_group_pkg::DATA_W;
	localparam int IW = add_group_pkg::INDEX_W;
	localparam int SW = add_group_pkg::SEL_W;

	// ----------------------------------------
	// state
	// ----------------------------------------
	exec_state_e                       state_reg;
	exec_state_e                       state_next;
	logic                              wait_reg;
	logic                              wait_next;
	logic [DW-1:0]                     rdata_reg;
	logic [DW-1:0]                     rdata_next;
	logic [add_group_pkg::INSTR_W-1:0] instr_reg;
	logic [add_group_pkg::INSTR_W-1:0] instr_next;
	logic [add_group_pkg::FLAG_W-1:0]  flags_reg;
	logic [add_group_pkg::FLAG_W-1:0]  flags_next;
	logic [DW-1:0]                     result_reg;
	logic [DW-1:0]                     result_next;
	logic                              done_reg;
	logic                              done_next;
	logic                              bad_op_reg;
	logic                              bad_op_next;
	logic [DW-1:0]                     instr_wide;
	logic [DW-1:0]                     flags_wide;

	logic [DW-1:0] global_q [add_group_pkg::GROUP_N];
	logic [DW-1:0] local_q  [add_group_pkg::GROUP_N];
	logic [DW-1:0] imm_q    [add_group_pkg::IMM_N];

	logic          glob_we;
	logic [IW-1:0] glob_idx;
	logic [DW-1:0] glob_data;
	logic          loc_we;
	logic [IW-1:0] loc_idx;
	logic [DW-1:0] loc_data;
	logic          imm_we;
	logic [SW-1:0] imm_idx;
	logic [DW-1:0] imm_data;

	logic          req;
	logic          take;
	logic          take_write;
	logic [IW-1:0] bus_grp_idx;
	logic [SW-1:0] bus_imm_idx;
	logic [DW-1:0] rd_value;
	logic [DW-1:0] rs_value;
	logic [DW-1:0] op_b;
	logic          op_cin;
	logic [DW-1:0] sum;
	logic          sum_c;
	logic          sum_v;
	logic          sum_z;
	logic          sum_n;

	// ----------------------------------------
	// decode and arithmetic
	// ----------------------------------------
	instr_fields_if fields ();

	assign fields.instr = instr_reg;

	op_decoder u_decoder
	(
		.fields (fields)
	);

	sum_unit #(.W(DW)) u_sum
	(
		.a_in         (rd_value),
		.b_in         (op_b),
		.carry_in     (op_cin),
		.sum_out      (sum),
		.carry_out    (sum_c),
		.overflow_out (sum_v),
		.zero_out     (sum_z),
		.negative_out (sum_n)
	);

	function automatic logic [DW-1:0] merge_bytes(input logic [DW-1:0] old_v,
		input logic [DW-1:0] new_v, input logic [3:0] be);
		logic [DW-1:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
			begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// operand selection
	// ----------------------------------------
	always_comb
	begin
		if (fields.dst_local) // RULE2
		begin
			rd_value = local_q[fields.dst_index];
		end
		else
		begin
			rd_value = global_q[fields.dst_index];
		end
		if (fields.src_local) // RULE1
		begin
			rs_value = local_q[fields.src_index];
		end
		else
		begin
			rs_value = global_q[fields.src_index];
		end
	end

	// signed or unsigned reads the same sum; overflow never traps
	always_comb
	begin
		op_b   = '0;
		op_cin = 1'b0;
		unique case (fields.op)
			add_group_pkg::OP_SUM:
			begin
				if (fields.src_is_status)
				begin
					op_cin = flags_reg[add_group_pkg::FLAG_C]; // RULE4
				end
				else
				begin
					op_b = rs_value; // RULE3
				end
			end
			add_group_pkg::OP_SUM_CARRY:
			begin
				op_cin = flags_reg[add_group_pkg::FLAG_C]; // RULE5
				if (!fields.src_is_status) // RULE7
				begin
					op_b = rs_value; // RULE5
				end
			end
			add_group_pkg::OP_SUM_IMM:
			begin
				if (fields.imm_sel == '0)
				begin
					op_cin = flags_reg[add_group_pkg::FLAG_C]
						&& (!flags_reg[add_group_pkg::FLAG_Z] || rd_value[0]); // RULE9
				end
				else
				begin
					op_b = imm_q[fields.imm_sel]; // RULE11
				end
			end
			add_group_pkg::OP_NONE:
			begin
				op_b = '0;
			end
		endcase
	end

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	// a request is only acknowledged while idle, so bus writes never
	// collide with a writeback into the register groups
	always_comb
	begin
		req         = avs_read_in || avs_write_in;
		take        = req && !wait_reg;
		take_write  = take && avs_write_in;
		bus_grp_idx = avs_address_in[5:2];
		bus_imm_idx = avs_address_in[6:2];
		wait_next   = 1'b1;
		if (req && wait_reg && (state_reg == ST_IDLE))
		begin
			wait_next = 1'b0;
		end
	end

	always_comb
	begin
		rdata_next = rdata_reg;
		// only reads load the data register, so it stands until the next read
		if ((wait_next == 1'b0) && avs_read_in)
		begin
			rdata_next = '0;
			if (avs_address_in == add_group_pkg::ADR_CTRL)
			begin
				rdata_next[add_group_pkg::STAT_BUSY]   = (state_reg != ST_IDLE);
				rdata_next[add_group_pkg::STAT_DONE]   = done_reg;
				rdata_next[add_group_pkg::STAT_BAD_OP] = bad_op_reg;
			end
			else if (avs_address_in == add_group_pkg::ADR_INSTR)
			begin
				rdata_next[add_group_pkg::INSTR_W-1:0] = instr_reg;
			end
			else if (avs_address_in == add_group_pkg::ADR_FLAGS)
			begin
				rdata_next[add_group_pkg::FLAG_W-1:0] = flags_reg;
			end
			else if (avs_address_in == add_group_pkg::ADR_RESULT)
			begin
				rdata_next = result_reg;
			end
			else if (avs_address_in[8:6] == add_group_pkg::REGION_GLOBAL)
			begin
				rdata_next = global_q[bus_grp_idx];
			end
			else if (avs_address_in[8:6] == add_group_pkg::REGION_LOCAL)
			begin
				rdata_next = local_q[bus_grp_idx];
			end
			else if (avs_address_in[8:7] == add_group_pkg::REGION_IMM)
			begin
				rdata_next = imm_q[bus_imm_idx];
			end
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			wait_reg  <= 1'b1;
			rdata_reg <= '0;
		end
		else
		begin
			wait_reg  <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	assign avs_waitrequest_out = wait_reg;
	assign avs_readdata_out    = rdata_reg;

	// ----------------------------------------
	// control, flags and execution
	// ----------------------------------------
	always_comb
	begin
		state_next  = state_reg;
		instr_next  = instr_reg;
		flags_next  = flags_reg;
		result_next = result_reg;
		done_next   = done_reg;
		bad_op_next = bad_op_reg;
		instr_wide  = merge_bytes({16'h0000, instr_reg}, avs_writedata_in, avs_byteenable_in);
		flags_wide  = merge_bytes({28'h0000000, flags_reg}, avs_writedata_in, avs_byteenable_in);
		if (take_write && (avs_address_in == add_group_pkg::ADR_INSTR))
		begin
			instr_next = instr_wide[add_group_pkg::INSTR_W-1:0];
		end
		if (take_write && (avs_address_in == add_group_pkg::ADR_FLAGS))
		begin
			flags_next = flags_wide[add_group_pkg::FLAG_W-1:0];
		end
		if (take_write && (avs_address_in == add_group_pkg::ADR_CTRL) && avs_byteenable_in[0])
		begin
			if (avs_writedata_in[add_group_pkg::CTRL_CLR_DONE])
			begin
				done_next = 1'b0;
			end
			if (avs_writedata_in[add_group_pkg::CTRL_START])
			begin
				state_next = ST_EXEC;
			end
		end
		unique case (state_reg)
			ST_IDLE:
			begin
			end
			ST_EXEC:
			begin
				state_next = ST_IDLE;
				done_next  = 1'b1;
				if (fields.op == add_group_pkg::OP_NONE)
				begin
					bad_op_next = 1'b1;
				end
				else
				begin
					bad_op_next = 1'b0;
					result_next = sum;
					flags_next[add_group_pkg::FLAG_Z] = sum_z; // RULE10
					flags_next[add_group_pkg::FLAG_N] = sum_n; // RULE10
					flags_next[add_group_pkg::FLAG_V] = sum_v; // RULE6
					flags_next[add_group_pkg::FLAG_C] = sum_c; // RULE10
				end
			end
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			state_reg  <= ST_IDLE;
			instr_reg  <= add_group_pkg::INSTR_RESET;
			flags_reg  <= add_group_pkg::FLAGS_RESET;
			result_reg <= '0;
			done_reg   <= 1'b0;
			bad_op_reg <= 1'b0;
		end
		else
		begin
			state_reg  <= state_next;
			instr_reg  <= instr_next;
			flags_reg  <= flags_next;
			result_reg <= result_next;
			done_reg   <= done_next;
			bad_op_reg <= bad_op_next;
		end
	end

	// ----------------------------------------
	// register groups and immediate table
	// ----------------------------------------
	always_comb
	begin
		glob_we   = take_write && (avs_address_in[8:6] == add_group_pkg::REGION_GLOBAL);
		glob_idx  = bus_grp_idx;
		glob_data = merge_bytes(global_q[bus_grp_idx], avs_writedata_in, avs_byteenable_in);
		loc_we    = take_write && (avs_address_in[8:6] == add_group_pkg::REGION_LOCAL);
		loc_idx   = bus_grp_idx;
		loc_data  = merge_bytes(local_q[bus_grp_idx], avs_writedata_in, avs_byteenable_in);
		imm_we    = take_write && (avs_address_in[8:7] == add_group_pkg::REGION_IMM)
			&& (bus_imm_idx != '0);
		imm_idx   = bus_imm_idx;
		imm_data  = merge_bytes(imm_q[bus_imm_idx], avs_writedata_in, avs_byteenable_in);
		if ((state_reg == ST_EXEC) && (fields.op != add_group_pkg::OP_NONE))
		begin
			glob_we   = !fields.dst_local; // RULE3
			glob_idx  = fields.dst_index;
			glob_data = sum;
			loc_we    = fields.dst_local; // RULE3
			loc_idx   = fields.dst_index;
			loc_data  = sum;
		end
	end

	// entry zero of the table stays zero: selector zero never reads it
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			for (int i = 0; i < add_group_pkg::GROUP_N; i++)
			begin
				global_q[i] <= '0;
				local_q[i]  <= '0;
			end
			for (int i = 0; i < add_group_pkg::IMM_N; i++)
			begin
				imm_q[i] <= '0;
			end
		end
		else
		begin
			if (glob_we)
			begin
				global_q[glob_idx] <= glob_data;
			end
			if (loc_we)
			begin
				local_q[loc_idx] <= loc_data;
			end
			if (imm_we)
			begin
				imm_q[imm_idx] <= imm_data;
			end
		end
	end

endmodule
`default_nettype wire

// *** verif/add_group_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module add_group_sva
(
	input wire logic        clk_in,
	input wire logic        reset_in,
	input wire logic [8:0]  avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0]  avs_byteenable_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic        avs_waitrequest_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	logic rd_ack;
	assign rd_ack = avs_read_in && !avs_waitrequest_out;

	// ----
	// bus handshake
	// ----
	AST_WAIT_ONE_LOW: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low for more than one cycle");
	AST_ACK_NEEDS_REQ: assert property (!avs_waitrequest_out |-> avs_read_in || avs_write_in)
		else $error("acknowledge without a request");
	AST_ACK_BOUND: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|-> ##[1:2] !avs_waitrequest_out)
		else $error("request not acknowledged in time");
	AST_RESET_QUIET: assert property ($fell(reset_in) |-> avs_waitrequest_out
		&& avs_readdata_out == 32'h0)
		else $error("bus not quiet after reset");
	AST_RDATA_HOLD: assert property ($changed(avs_readdata_out) |-> rd_ack)
		else $error("read data moved outside a read acknowledge");

	// ----
	// register contents
	// ----
	AST_FLAGS_RSVD: assert property (rd_ack && avs_address_in == 9'h008
		|-> avs_readdata_out[31:4] == 28'h0)
		else $error("flag word has bits beyond the four flags");
	AST_CTRL_RSVD: assert property (rd_ack && avs_address_in == 9'h000
		|-> avs_readdata_out[31:3] == 29'h0)
		else $error("control word reserved bits set");
	AST_IMM0_EMPTY: assert property (rd_ack && avs_address_in == 9'h180
		|-> avs_readdata_out == 32'h0)
		else $error("immediate entry zero holds a value");
	AST_UNMAPPED: assert property (rd_ack && !avs_address_in[8] && avs_address_in[7:4] != 4'h0
		|-> avs_readdata_out == 32'h0)
		else $error("unmapped address read nonzero");

	COV_READ: cover property (rd_ack);
	COV_WRITE: cover property (avs_write_in && !avs_waitrequest_out);
	COV_STALL: cover property ((avs_read_in || avs_write_in) && avs_waitrequest_out [*2]);
endmodule
bind add_group_top add_group_sva u_add_group_sva (.clk_in(clk_in), .reset_in(reset_in),
	.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
	.avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out));
`default_nettype wire

// *** verif/avalon_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module avalon_master_model
(
	input  wire logic        clk_in,
	input  wire logic        waitrequest_in,
	input  wire logic [31:0] readdata_in,
	output logic      [8:0]  address_out,
	output logic             read_out,
	output logic             write_out,
	output logic      [31:0] writedata_out,
	output logic      [3:0]  byteenable_out
);
	initial
	begin
		address_out = 9'h000;
		read_out = 1'b0;
		write_out = 1'b0;
		writedata_out = 32'h0;
		byteenable_out = 4'hf;
	end

	// lanes change only between transfers, while read and write are low
	task automatic set_lanes(input logic [3:0] m);
		byteenable_out <= m;
	endtask

	// request held until the edge that samples the ack; bounded so a dead slave ends the run
	task automatic access(input logic wr, input logic [8:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic ok);
		int n;
		ok = 1'b0;
		q = 32'h0;
		@(posedge clk_in);
		address_out <= a;
		writedata_out <= d;
		read_out <= !wr;
		write_out <= wr;
		for (n = 0; n < 20 && !ok; n++)
		begin
			@(posedge clk_in);
			if (waitrequest_in === 1'b0)
			begin
				ok = 1'b1;
				q = readdata_in;
				read_out <= 1'b0;
				write_out <= 1'b0;
			end
		end
	endtask
endmodule
`default_nettype wire

// *** verif/test_add_group_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_add_group_top;
	logic        clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic [8:0]  address;
	logic        rd;
	logic        wrq;
	logic [31:0] wdata;
	logic [3:0]  be;
	logic [31:0] rdata;
	logic        waitreq;
	int          error_cnt = 0;
	int          samples_checked = 0;

	always #50 clk_in = ~clk_in;

	add_group_top u_add_group_top (.clk_in(clk_in), .reset_in(reset_in),
		.avs_address_in(address), .avs_read_in(rd), .avs_write_in(wrq),
		.avs_writedata_in(wdata), .avs_byteenable_in(be),
		.avs_readdata_out(rdata), .avs_waitrequest_out(waitreq));
	avalon_master_model u_avalon_master_model (.clk_in(clk_in), .waitrequest_in(waitreq),
		.readdata_in(rdata), .address_out(address), .read_out(rd), .write_out(wrq),
		.writedata_out(wdata), .byteenable_out(be));

	// ----
	// helpers
	// ----
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d,
		output logic [31:0] q);
		logic ok;
		u_avalon_master_model.access(w, a, d, q, ok);
		chk("bus ack", 32'h1, {31'h0, ok});
		if (!ok)
			report_and_stop();
	endtask

	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input string what, input logic [8:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(what, exp, q);
	endtask

	function automatic logic [8:0] reg_adr(input logic loc, input logic [3:0] i);
		return {2'b10, loc, i, 2'b00};
	endfunction

	task automatic run(input logic [15:0] instr, output logic [31:0] ctrl);
		int n;
		wr(9'h004, {16'h0, instr});
		wr(9'h000, 32'h1);
		ctrl = 32'h0;
		for (n = 0; n < 10 && ctrl[1] !== 1'b1; n++)
			bus(1'b0, 9'h000, 32'h0, ctrl);
		chk("done", 32'h2, ctrl & 32'h2);
		if (ctrl[1] !== 1'b1)
			report_and_stop();
		wr(9'h000, 32'h2);
	endtask

	// expected sum and flags worked out here, independent of the datapath
	task automatic exec_case(input logic [5:0] opc, input logic d, input logic s,
		input logic [3:0] rdi, input logic [3:0] rsi, input logic [31:0] dv,
		input logic [31:0] sv, input logic [3:0] fin);
		logic [31:0] b;
		logic [31:0] ctrl;
		logic [32:0] t;
		logic ci;
		logic v;
		wr(reg_adr(d, rdi), dv);
		b = sv;
		ci = fin[0] & (opc == 6'h14 || (!s && rsi == 4'h1));
		if (opc == 6'h1a)
		begin
			wr({2'b11, s, rsi, 2'b00}, sv);
			ci = 1'b0;
			if ({s, rsi} == 5'h0)
			begin
				b = 32'h0;
				ci = fin[0] & (!fin[1] | dv[0]);
			end
		end
		else if (!s && rsi == 4'h1)
			b = 32'h0;
		else
			wr(reg_adr(s, rsi), sv);
		wr(9'h008, {28'h0, fin});
		run({opc, d, s, rdi, rsi}, ctrl);
		chk("bad op", 32'h0, ctrl & 32'h4);
		t = {1'b0, dv} + {1'b0, b} + {32'h0, ci};
		v = (dv[31] == b[31]) && (t[31] != dv[31]);
		rd_chk("sum", reg_adr(d, rdi), t[31:0]);
		rd_chk("flags", 9'h008, {28'h0, v, t[31], t[31:0] == 32'h0, t[32]});
		rd_chk("result", 9'h00c, t[31:0]);
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_reset_vals();
		rd_chk("flags", 9'h008, 32'h0);
		rd_chk("ctrl", 9'h000, 32'h0);
		rd_chk("local 15", reg_adr(1'b1, 4'hf), 32'h0);
		wr(9'h010, 32'hffff_ffff);
		rd_chk("unmapped", 9'h010, 32'h0);
		wr(9'h180, 32'h1234_5678);
		rd_chk("imm 0", 9'h180, 32'h0);
		$display("test reset values done");
	endtask

	task automatic t_plain();
		exec_case(6'h0a, 1'b0, 1'b0, 4'h3, 4'h4, 32'h7fff_ffff, 32'h1, 4'h1);
		exec_case(6'h0a, 1'b1, 1'b0, 4'h2, 4'h5, 32'hffff_ffff, 32'h1, 4'h0);
		exec_case(6'h0a, 1'b0, 1'b1, 4'h7, 4'h7, 32'h8000_0000, 32'h8000_0000, 4'h0);
		$display("test plain add done");
	endtask

	task automatic t_status_carry();
		exec_case(6'h0a, 1'b0, 1'b0, 4'h6, 4'h1, 32'h0000_00ff, 32'h0, 4'h1);
		exec_case(6'h14, 1'b1, 1'b0, 4'h6, 4'h1, 32'hffff_ffff, 32'h0, 4'h1);
		exec_case(6'h14, 1'b0, 1'b1, 4'h8, 4'h9, 32'h7fff_fffe, 32'h1, 4'h1);
		exec_case(6'h14, 1'b1, 1'b1, 4'h0, 4'hf, 32'h1, 32'h2, 4'h0);
		$display("test status and carry done");
	endtask

	task automatic t_imm();
		exec_case(6'h1a, 1'b0, 1'b0, 4'ha, 4'h1, 32'h10, 32'h0000_0100, 4'h0);
		exec_case(6'h1a, 1'b1, 1'b1, 4'ha, 4'h1, 32'h10, 32'hffff_fff0, 4'h0);
		exec_case(6'h1a, 1'b0, 1'b1, 4'hb, 4'hf, 32'h5, 32'h8000_0000, 4'h0);
		exec_case(6'h1a, 1'b0, 1'b0, 4'hc, 4'h0, 32'h2, 32'h0, 4'h3);
		exec_case(6'h1a, 1'b0, 1'b0, 4'hc, 4'h0, 32'h3, 32'h0, 4'h3);
		exec_case(6'h1a, 1'b0, 1'b0, 4'hc, 4'h0, 32'hffff_ffff, 32'h0, 4'h1);
		$display("test immediate done");
	endtask

	task automatic t_bad_op();
		logic [31:0] ctrl;
		wr(reg_adr(1'b0, 4'hd), 32'h55);
		run({6'h0b, 1'b0, 1'b0, 4'hd, 4'he}, ctrl);
		chk("bad op", 32'h4, ctrl & 32'h4);
		rd_chk("dest kept", reg_adr(1'b0, 4'hd), 32'h55);
		$display("test bad opcode done");
	endtask

	task automatic t_lanes();
		wr(reg_adr(1'b0, 4'h2), 32'h1111_1111);
		u_avalon_master_model.set_lanes(4'h5);
		wr(reg_adr(1'b0, 4'h2), 32'haabb_ccdd);
		u_avalon_master_model.set_lanes(4'hf);
		rd_chk("lane merge", reg_adr(1'b0, 4'h2), 32'h11bb_11dd);
		$display("test byte lanes done");
	endtask

	initial
	begin
		repeat (8) @(posedge clk_in);
		reset_in <= 1'b0;
		t_reset_vals();
		t_plain();
		t_status_carry();
		t_imm();
		t_bad_op();
		t_lanes();
		report_and_stop();
	end
endmodule
`default_nettype wire
